// *** fisc_pkg.sv ***
// package for the flash ID read and program/erase suspend command block
// assumes a 125 MHz system clock and a host that drives chip select and clock
package fisc_pkg;
	// opcodes handled here
	localparam logic [7:0] OP_DUAL_ID  = 8'h92;
	localparam logic [7:0] OP_QUAD_ID  = 8'h94;
	localparam logic [7:0] OP_IDENT    = 8'h9F;
	localparam logic [7:0] OP_SUSP_A   = 8'h75;
	localparam logic [7:0] OP_SUSP_B   = 8'hB0;
	localparam logic [7:0] OP_RESUME_A = 8'h7A;
	localparam logic [7:0] OP_RESUME_B = 8'h30;
	// opcodes passed on to the rest of the device
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_FAST     = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO  = 8'hEB;
	localparam logic [7:0] OP_PARAM    = 8'h5A;
	localparam logic [7:0] OP_SL_ID    = 8'h90;
	localparam logic [7:0] OP_SEC_RD   = 8'h48;
	localparam logic [7:0] OP_WRAP     = 8'h77;
	localparam logic [7:0] OP_WR_EN    = 8'h06;
	localparam logic [7:0] OP_PROG_1   = 8'h02;
	localparam logic [7:0] OP_PROG_2   = 8'hA2;
	localparam logic [7:0] OP_PROG_4   = 8'h32;
	localparam logic [7:0] OP_STAT1    = 8'h05;
	localparam logic [7:0] OP_STAT2    = 8'h35;
	localparam logic [7:0] OP_RST_EN   = 8'h66;
	localparam logic [7:0] OP_RST      = 8'h99;
	// id ordering address
	localparam logic [7:0] ADDR_DEV_FIRST = 8'h01;
	// header clock counts after the opcode
	localparam logic [5:0] DUAL_ADDR_END = 6'h0C;
	localparam logic [5:0] DUAL_HDR_END  = 6'h10;
	localparam logic [5:0] QUAD_ADDR_END = 6'h06;
	localparam logic [5:0] QUAD_HDR_END  = 6'h0C;
	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// status bit positions
	localparam int SR_PSUS_BIT = 15;
	localparam int SR_ESUS_BIT = 10;
	// running operation kinds
	localparam logic [2:0] KIND_PAGE_PROG = 3'h0;
	localparam logic [2:0] KIND_CHIP_ERASE = 3'h5;
	// suspend latencies
	localparam int CLK_PERIOD_NS = 8;
	localparam int PSUS_LAT_NS   = 20000;
	localparam int ESUS_LAT_NS   = 20000;
	localparam int PSUS_LAT_CYC  = (PSUS_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ESUS_LAT_CYC  = (ESUS_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {PH_CMD, PH_HDR, PH_OUT, PH_SKIP} fisc_phase_type;
	typedef enum logic [1:0] {SUS_RUN, SUS_WAIT, SUS_HELD} fisc_sus_type;
	typedef struct packed {
		logic [7:0] mfr;
		logic [7:0] dev;
		logic [7:0] mem_type;
		logic [7:0] capacity;
	} fisc_id_type;
endpackage : fisc_pkg

// *** fisc_ctrl.sv ***
// flash ID reads (single, dual, quad line) and program/erase suspend control
// assumes a host SPI master on the pins and an array engine reporting busy
//
// Operation
// R1 - dual ID read: 92h, two dummy bytes, address byte, mode byte, then IDs
// R2 - dual ID read moves address in and IDs out on IO0 and IO1
// R3 - multi-line ID bytes leave on falling clock edges, MSB first
// R4 - address 01h returns device ID first, manufacturer ID second
// R5 - address 00h returns manufacturer ID first, then device ID
// R6 - IDs alternate without limit while chip select stays low
// R7 - host ends dual ID read by raising chip select
// R8 - quad ID read: 94h, two dummies, address, mode, two dummies, then IDs
// R9 - quad ID read moves address and IDs over IO0 to IO3
// R10 - quad ID read accepted only with quad enable bit set
// R11 - 9Fh returns manufacturer ID, memory type, capacity
// R12 - 9Fh: 24 ID bits on serial output at falling edges after opcode
// R13 - 9Fh during a running program or erase is not decoded
// R14 - host avoids 9Fh during deep power-down
// R15 - chip select high ends 9Fh output, back to standby
// R16 - 75h or B0h suspends page program and page, sector, block erases
// R17 - reads allowed everywhere except the region under program or erase
// R18 - after latency, clear write enable latch, set matching suspend flag
// R19 - program suspend is status bit 15, erase suspend bit 10
// R20 - flag follows suspended kind, cleared on resume
// R21 - after latency accept reads, ID reads, security read, wrap, resume
// R22 - write enable and page programs only during erase suspend
// R23 - status, security read, reset enable, reset accepted without latency
// R24 - suspend with nothing running changes nothing
// R25 - data lines driven only during ID output, released at chip select high
`timescale 1ns/10ps
`default_nettype none
module fisc_ctrl #(
	parameter int PSUS_CYC = fisc_pkg::PSUS_LAT_CYC,
	parameter int ESUS_CYC = fisc_pkg::ESUS_LAT_CYC
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// serial pins
	input  wire logic                 cs_n_pin,
	input  wire logic                 sclk_pin,
	input  wire logic [3:0]           io_in,
	output var  logic [3:0]           io_out_ff,
	output var  logic [3:0]           io_oe_ff,
	// array engine and configuration
	input  wire logic                 op_busy,
	input  wire logic [2:0]           op_kind,
	input  wire logic                 quad_enable_bit,
	input  wire fisc_pkg::fisc_id_type id_values,
	// suspend control and status
	output var  logic                 op_suspend_ff,
	output var  logic                 wr_latch_clr_ff,
	output var  logic [15:0]          status_sus_ff,
	output var  logic [2:0]           locked_kind_ff,
	// commands passed to the rest of the device
	output var  logic                 cmd_accept_ff,
	output var  logic [7:0]           cmd_code_ff
);
	logic                     cs_s1_ff, cs_s2_ff;
	logic                     sck_s1_ff, sck_s2_ff, sck_s3_ff;
	logic [3:0]               io_s1_ff, io_s2_ff;
	logic                     sel, sck_rise, sck_fall;
	fisc_pkg::fisc_phase_type phase_ff;
	fisc_pkg::fisc_sus_type   sus_st_ff;
	logic [7:0]               cmd_sh_ff, hdr_ff, out_sh_ff;
	logic [5:0]               cnt_ff;
	logic [2:0]               lanes_ff;
	logic                     ident_ff, dev_first_ff;
	logic [1:0]               idx_ff;
	logic [3:0]               out_left_ff;
	logic [15:0]              lat_ff, dbg_wait_ff;
	logic [7:0]               op_in, nxt_byte, src, nxt_hdr;
	logic                     op_done, ok, handled, id_ok;
	logic                     dec_dual, dec_quad, dec_ident, dec_sus, dec_res;
	logic                     any_time, read_set, erase_only, psus, esus;
	logic [5:0]               addr_end, hdr_end;

	// pins are asynchronous to sys_clk
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_s1_ff  <= 1'b1;
			cs_s2_ff  <= 1'b1;
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_s3_ff <= 1'b0;
			io_s1_ff  <= 4'h0;
			io_s2_ff  <= 4'h0;
		end else begin
			cs_s1_ff  <= cs_n_pin;
			cs_s2_ff  <= cs_s1_ff;
			sck_s1_ff <= sclk_pin;
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
			io_s1_ff  <= io_in;
			io_s2_ff  <= io_s1_ff;
		end
	end

	assign sel      = ~cs_s2_ff;
	assign sck_rise = sck_s2_ff & ~sck_s3_ff;
	assign sck_fall = ~sck_s2_ff & sck_s3_ff;
	assign psus     = status_sus_ff[fisc_pkg::SR_PSUS_BIT];
	assign esus     = status_sus_ff[fisc_pkg::SR_ESUS_BIT];

	// opcode decode and the suspend-time command filter
	always_comb begin
		op_in   = {cmd_sh_ff[6:0], io_s2_ff[0]};
		op_done = sel & sck_rise & (phase_ff == fisc_pkg::PH_CMD) & (cnt_ff == 6'h07);
		any_time = (op_in == fisc_pkg::OP_STAT1) | (op_in == fisc_pkg::OP_STAT2)
			| (op_in == fisc_pkg::OP_SEC_RD) | (op_in == fisc_pkg::OP_RST_EN) | (op_in == fisc_pkg::OP_RST);
		read_set = (op_in == fisc_pkg::OP_READ) | (op_in == fisc_pkg::OP_FAST)
			| (op_in == fisc_pkg::OP_DUAL_OUT) | (op_in == fisc_pkg::OP_QUAD_OUT)
			| (op_in == fisc_pkg::OP_DUAL_IO) | (op_in == fisc_pkg::OP_QUAD_IO)
			| (op_in == fisc_pkg::OP_PARAM) | (op_in == fisc_pkg::OP_IDENT)
			| (op_in == fisc_pkg::OP_SL_ID) | (op_in == fisc_pkg::OP_DUAL_ID)
			| (op_in == fisc_pkg::OP_QUAD_ID) | (op_in == fisc_pkg::OP_WRAP)
			| (op_in == fisc_pkg::OP_RESUME_A) | (op_in == fisc_pkg::OP_RESUME_B);
		erase_only = (op_in == fisc_pkg::OP_WR_EN) | (op_in == fisc_pkg::OP_PROG_1)
			| (op_in == fisc_pkg::OP_PROG_2) | (op_in == fisc_pkg::OP_PROG_4);
		dec_res = op_done & ((op_in == fisc_pkg::OP_RESUME_A) | (op_in == fisc_pkg::OP_RESUME_B));
		dec_sus = op_done & ((op_in == fisc_pkg::OP_SUSP_A) | (op_in == fisc_pkg::OP_SUSP_B));
		if (sus_st_ff == fisc_pkg::SUS_HELD) begin
			ok = any_time | read_set | (erase_only & esus); // R21 R22 R23
		end else if (sus_st_ff == fisc_pkg::SUS_WAIT) begin
			ok = any_time; // R23
		end else if (op_busy) begin
			ok = any_time;
		end else begin
			ok = ~dec_res;
		end
		// id reads are not decoded while an operation runs
		id_ok     = op_done & ok; // R13
		dec_dual  = id_ok & (op_in == fisc_pkg::OP_DUAL_ID);
		dec_quad  = id_ok & (op_in == fisc_pkg::OP_QUAD_ID) & quad_enable_bit; // R10
		dec_ident = id_ok & (op_in == fisc_pkg::OP_IDENT);
		handled   = (op_in == fisc_pkg::OP_DUAL_ID) | (op_in == fisc_pkg::OP_QUAD_ID)
			| (op_in == fisc_pkg::OP_IDENT) | dec_sus | dec_res;
	end

	// header shift and output byte selection
	always_comb begin
		addr_end = (lanes_ff == fisc_pkg::LANES_4) ? fisc_pkg::QUAD_ADDR_END : fisc_pkg::DUAL_ADDR_END;
		hdr_end  = (lanes_ff == fisc_pkg::LANES_4) ? fisc_pkg::QUAD_HDR_END : fisc_pkg::DUAL_HDR_END; // R1 R8
		nxt_hdr  = (lanes_ff == fisc_pkg::LANES_4) ? {hdr_ff[3:0], io_s2_ff} : {hdr_ff[5:0], io_s2_ff[1:0]}; // R2 R9
		if (ident_ff) begin
			case (idx_ff)
				2'h0:    nxt_byte = id_values.mfr; // R11
				2'h1:    nxt_byte = id_values.mem_type;
				default: nxt_byte = id_values.capacity;
			endcase
		end else begin
			nxt_byte = (idx_ff[0] ^ dev_first_ff) ? id_values.dev : id_values.mfr; // R4 R5 R6
		end
		src = (out_left_ff == 4'h0) ? nxt_byte : out_sh_ff;
	end

	// serial command, header and id output engine
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_ff     <= fisc_pkg::PH_CMD;
			cmd_sh_ff    <= 8'h00;
			hdr_ff       <= 8'h00;
			cnt_ff       <= 6'h00;
			lanes_ff     <= fisc_pkg::LANES_1;
			ident_ff     <= 1'b0;
			dev_first_ff <= 1'b0;
			idx_ff       <= 2'h0;
			out_sh_ff    <= 8'h00;
			out_left_ff  <= 4'h0;
			io_out_ff    <= 4'h0;
			io_oe_ff     <= 4'h0;
		end else if (!sel) begin
			// chip select high ends any frame and frees the lines
			phase_ff    <= fisc_pkg::PH_CMD; // R7 R15
			cnt_ff      <= 6'h00;
			out_left_ff <= 4'h0;
			idx_ff      <= 2'h0;
			io_oe_ff    <= 4'h0; // R25
		end else if (sck_rise && phase_ff == fisc_pkg::PH_CMD) begin
			cmd_sh_ff <= op_in;
			cnt_ff    <= cnt_ff + 6'h01;
			if (op_done) begin
				cnt_ff   <= 6'h00;
				ident_ff <= dec_ident;
				if (dec_dual) begin
					phase_ff <= fisc_pkg::PH_HDR;
					lanes_ff <= fisc_pkg::LANES_2;
				end else if (dec_quad) begin
					phase_ff <= fisc_pkg::PH_HDR;
					lanes_ff <= fisc_pkg::LANES_4;
				end else if (dec_ident) begin
					phase_ff <= fisc_pkg::PH_OUT; // R12
					lanes_ff <= fisc_pkg::LANES_1;
				end else begin
					phase_ff <= fisc_pkg::PH_SKIP;
				end
			end
		end else if (sck_rise && phase_ff == fisc_pkg::PH_HDR) begin
			hdr_ff <= nxt_hdr;
			cnt_ff <= cnt_ff + 6'h01;
			if (cnt_ff + 6'h01 == addr_end) begin
				dev_first_ff <= (nxt_hdr == fisc_pkg::ADDR_DEV_FIRST);
			end
			if (cnt_ff + 6'h01 == hdr_end) begin
				phase_ff <= fisc_pkg::PH_OUT;
			end
		end else if (sck_fall && phase_ff == fisc_pkg::PH_OUT) begin
			// each falling edge puts the next MSB-first group on the lines
			case (lanes_ff)
				fisc_pkg::LANES_4: begin
					io_out_ff <= src[7:4]; // R3 R9
					io_oe_ff  <= 4'hF;
					out_sh_ff <= {src[3:0], 4'h0};
				end
				fisc_pkg::LANES_2: begin
					io_out_ff <= {2'b00, src[7:6]}; // R3 R2
					io_oe_ff  <= 4'h3;
					out_sh_ff <= {src[5:0], 2'b00};
				end
				default: begin
					io_out_ff <= {2'b00, src[7], 1'b0}; // R12
					io_oe_ff  <= 4'h2;
					out_sh_ff <= {src[6:0], 1'b0};
				end
			endcase
			out_left_ff <= ((out_left_ff == 4'h0) ? fisc_pkg::BYTE_BITS : out_left_ff) - {1'b0, lanes_ff};
			if (out_left_ff == 4'h0) begin
				idx_ff <= (ident_ff && idx_ff == 2'h2) ? 2'h0 : idx_ff + 2'h1; // R6
			end
		end
	end

	// commands for the rest of the device, filtered while suspended
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_accept_ff <= 1'b0;
			cmd_code_ff   <= 8'h00;
		end else begin
			cmd_accept_ff <= op_done & ok & ~handled; // R21 R22 R23
			if (op_done) begin
				cmd_code_ff <= op_in;
			end
		end
	end

	// suspend sequencing; hold the array engine, wait latency, flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sus_st_ff      <= fisc_pkg::SUS_RUN;
			lat_ff         <= 16'h0000;
			op_suspend_ff  <= 1'b0;
			wr_latch_clr_ff <= 1'b0;
			status_sus_ff  <= 16'h0000;
			locked_kind_ff <= 3'h0;
		end else begin
			wr_latch_clr_ff <= 1'b0;
			case (sus_st_ff)
				fisc_pkg::SUS_RUN: begin
					// chip erase cannot be suspended; idle device ignores it
					if (dec_sus && op_busy && op_kind != fisc_pkg::KIND_CHIP_ERASE) begin // R24
						sus_st_ff      <= fisc_pkg::SUS_WAIT; // R16
						op_suspend_ff  <= 1'b1;
						locked_kind_ff <= op_kind; // R17
						lat_ff <= (op_kind == fisc_pkg::KIND_PAGE_PROG) ? 16'(PSUS_CYC - 1) : 16'(ESUS_CYC - 1);
					end
				end
				fisc_pkg::SUS_WAIT: begin
					lat_ff <= lat_ff - 16'h0001;
					if (lat_ff == 16'h0000) begin
						sus_st_ff    <= fisc_pkg::SUS_HELD;
						wr_latch_clr_ff <= 1'b1; // R18
						if (locked_kind_ff == fisc_pkg::KIND_PAGE_PROG) begin
							status_sus_ff[fisc_pkg::SR_PSUS_BIT] <= 1'b1; // R19 R20
						end else begin
							status_sus_ff[fisc_pkg::SR_ESUS_BIT] <= 1'b1; // R19 R20
						end
					end
				end
				default: begin
					if (dec_res) begin
						sus_st_ff     <= fisc_pkg::SUS_RUN;
						op_suspend_ff <= 1'b0;
						status_sus_ff <= 16'h0000; // R20
					end
				end
			endcase
		end
	end

	// helper count of latency cycles, read only by assertions
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dbg_wait_ff <= 16'h0000;
		end else if (sus_st_ff == fisc_pkg::SUS_WAIT) begin
			dbg_wait_ff <= dbg_wait_ff + 16'h0001;
		end else if (sus_st_ff == fisc_pkg::SUS_RUN) begin
			dbg_wait_ff <= 16'h0000;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_sus_cmd;
		dec_sus && op_busy && sus_st_ff == fisc_pkg::SUS_RUN && op_kind != fisc_pkg::KIND_CHIP_ERASE;
	endsequence
	sequence s_wait_entry;
		sus_st_ff == fisc_pkg::SUS_WAIT && op_suspend_ff;
	endsequence

	a_sus_enter: assert property (s_sus_cmd |=> s_wait_entry) // R16
		else $error("suspend did not start waiting");
	a_sus_idle: assert property (dec_sus && !op_busy && sus_st_ff == fisc_pkg::SUS_RUN
		|=> status_sus_ff == 16'h0000 && !op_suspend_ff) // R24
		else $error("idle suspend changed state");
	a_psus_lat: assert property ($rose(psus) |-> dbg_wait_ff == 16'(PSUS_CYC) && wr_latch_clr_ff) // R18
		else $error("program suspend flag not after latency");
	a_esus_kind: assert property ($rose(esus) |-> locked_kind_ff != fisc_pkg::KIND_PAGE_PROG && !psus) // R20
		else $error("erase flag for wrong kind");
	a_resume_clear: assert property (sus_st_ff == fisc_pkg::SUS_HELD && dec_res
		|=> status_sus_ff == 16'h0000 ##1 !op_suspend_ff) // R20
		else $error("resume left a flag set");
	a_oe_release: assert property (cs_s2_ff |=> io_oe_ff == 4'h0) // R25
		else $error("lines driven after deselect");
	a_oe_phase: assert property (io_oe_ff != 4'h0 |-> phase_ff == fisc_pkg::PH_OUT) // R25
		else $error("lines driven outside id output");
	a_fall_drive: assert property (sel && $changed(io_out_ff) |-> $past(sck_fall)) // R3
		else $error("id data moved off a falling edge");
	a_ident_busy: assert property (op_done && op_in == fisc_pkg::OP_IDENT && op_busy
		&& sus_st_ff != fisc_pkg::SUS_HELD |=> phase_ff == fisc_pkg::PH_SKIP) // R13
		else $error("id read decoded while busy");
	a_quad_gate: assert property (op_done && op_in == fisc_pkg::OP_QUAD_ID && !quad_enable_bit
		|=> phase_ff != fisc_pkg::PH_HDR) // R10
		else $error("quad id read without quad enable");
	a_write_enable_cmd_prog: assert property (op_done && erase_only && psus |=> !cmd_accept_ff) // R22
		else $error("write command accepted in program suspend");
endmodule : fisc_ctrl
`default_nettype wire

// *** fisc_host.sv ***
// host serial flash controller model: chip select, serial clock, IO lanes
// assumes one caller runs frame() at a time; the serial clock idles low between frames
`timescale 1ns/10ps
`default_nettype none
module fisc_host (
	// system clock
	input  wire logic       sys_clk,
	// device side of the lanes
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe,
	// host pins
	output var  logic       cs_n,
	output var  logic       sclk,
	output var  logic [3:0] io_line
);
	logic [3:0] drv_val;
	logic [3:0] drv_en;
	logic [3:0] junk;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv_val = 4'h0;
		drv_en = 4'h0;
		junk = 4'h5;
	end

	// released lanes toggle so a stale level never passes for data
	always @(posedge sys_clk) junk <= ~junk;

	always_comb begin
		for (int b = 0; b < 4; b++) io_line[b] = dev_oe[b] ? dev_out[b] : (drv_en[b] ? drv_val[b] : junk[b]);
	end

	// one serial clock of 160 ns: data set with clock low, sampled at the rise
	task automatic pulse(input logic [3:0] v, input logic [3:0] en, output logic [3:0] smp);
		drv_val <= v;
		drv_en <= en;
		repeat (10) @(posedge sys_clk);
		sclk <= 1'b1;
		smp = io_line;
		repeat (10) @(posedge sys_clk);
		sclk <= 1'b0;
	endtask : pulse

	task automatic frame(input logic [7:0] op, input logic [47:0] hdr, input int hclk, input int ln,
		input int oclk, input int ol, output logic [47:0] cap);
		logic [47:0] sh;
		logic [3:0]  s;
		sh = hdr;
		cap = '0;
		@(posedge sys_clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int k = 0; k < 8; k++) pulse({3'h0, op[7 - k]}, 4'h1, s);
		for (int k = 0; k < hclk; k++) begin
			pulse(sh[47:44] >> (4 - ln), 4'hF >> (4 - ln), s);
			sh = sh << ln;
		end
		for (int k = 0; k < oclk; k++) begin
			pulse(4'h0, 4'h0, s);
			cap = (cap << ol) | ((ol == 1) ? {47'h0, s[1]} : {44'h0, s & (4'hF >> (4 - ol))});
		end
		repeat (4) @(posedge sys_clk);
		cs_n <= 1'b1;
		drv_en <= 4'h0;
		repeat (8) @(posedge sys_clk);
	endtask : frame
	// never sends a deep power-down, so no identification read meets one
endmodule : fisc_host
`default_nettype wire

// *** test_flash_id_read_and_suspend_control.sv ***
// testbench for the ID read and suspend block, driven through the host model
// assumes the suspend latency parameters are shortened to SUS_CYC
`timescale 1ns/10ps
`default_nettype none
module test_flash_id_read_and_suspend_control;
	localparam int SUS_CYC = 600;
	logic                  sys_clk, rst_b, cs_n, sclk, op_busy, quad_enable_bit;
	logic                  op_suspend, wr_latch_clr, cmd_accept;
	logic [3:0]            io_line, io_out, io_oe;
	logic [2:0]            op_kind, locked_kind;
	logic [15:0]           status_sus;
	logic [7:0]            cmd_code, acc_code;
	logic [47:0]           cap;
	fisc_pkg::fisc_id_type id_values;
	int                    fail_count = 0, samples_checked = 0, oe_cnt = 0, acc_cnt = 0, clr_cnt = 0;
	logic [7:0]            m, d, t, c;
	logic [7:0]            ok_list [10] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h5A, 8'h90, 8'h48, 8'h77};
	logic [7:0]            wr_list [4] = '{8'h06, 8'h02, 8'hA2, 8'h32};

	fisc_host host (.sys_clk(sys_clk), .dev_out(io_out), .dev_oe(io_oe), .cs_n(cs_n), .sclk(sclk), .io_line(io_line));
	fisc_ctrl #(.PSUS_CYC(SUS_CYC), .ESUS_CYC(SUS_CYC)) DUT (
		.sys_clk(sys_clk), .rst_b(rst_b), .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in(io_line),
		.io_out_ff(io_out), .io_oe_ff(io_oe), .op_busy(op_busy), .op_kind(op_kind),
		.quad_enable_bit(quad_enable_bit), .id_values(id_values), .op_suspend_ff(op_suspend),
		.wr_latch_clr_ff(wr_latch_clr), .status_sus_ff(status_sus), .locked_kind_ff(locked_kind),
		.cmd_accept_ff(cmd_accept), .cmd_code_ff(cmd_code));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (io_oe !== 4'h0) oe_cnt <= oe_cnt + 1;
		if (wr_latch_clr === 1'b1) clr_cnt <= clr_cnt + 1;
		if (cmd_accept === 1'b1) begin
			acc_cnt <= acc_cnt + 1;
			acc_code <= cmd_code;
		end
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// identification frame; ans says whether the device should answer at all
	task automatic idr(input logic [7:0] op, input logic [7:0] addr, input logic [47:0] exp, input bit ans);
		int o0;
		o0 = oe_cnt;
		if (op == 8'h9F) host.frame(op, 48'h0, 0, 1, 48, 1, cap);
		else if (op == 8'h92) host.frame(op, {16'h0, addr, 24'h0}, 16, 2, 16, 2, cap);
		else host.frame(op, {16'h0, addr, 24'h0}, 12, 4, 8, 4, cap);
		if (ans) check(cap, exp);
		check(48'(oe_cnt != o0), 48'(ans));
		check({44'h0, io_oe}, 48'h0);
	endtask : idr

	task automatic acc(input logic [7:0] op, input bit exp);
		int a0;
		a0 = acc_cnt;
		host.frame(op, 48'h0, 0, 1, 0, 1, cap);
		check(48'(acc_cnt - a0), 48'(exp));
		if (exp) check({40'h0, acc_code}, {40'h0, op});
	endtask : acc

	task automatic wait_status(input logic [15:0] e);
		for (int n = 0; n < 1000 && status_sus !== e; n++) @(posedge sys_clk);
		// step off the edge so the latch-clear pulse of this cycle is counted
		@(negedge sys_clk);
		check({32'h0, status_sus}, {32'h0, e});
	endtask : wait_status

	initial begin
		// about three times the expected length of the tests
		#400_000;
		fail_count++;
		complete_run();
	end

	initial begin
		{m, d, t, c} = {8'h5C, 8'h16, 8'h60, 8'h17}; // arbitrary ID values
		id_values = {m, d, t, c};
		rst_b = 1'b0;
		op_busy = 1'b0;
		op_kind = 3'h0;
		quad_enable_bit = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check({27'h0, status_sus, op_suspend, io_oe}, 48'h0);
		idr(8'h9F, 8'h00, {m, t, c, m, t, c}, 1);
		host.frame(8'h9F, 48'h0, 0, 1, 5, 1, cap);
		check(cap, {43'h0, m[7:3]});
		idr(8'h9F, 8'h00, {m, t, c, m, t, c}, 1);
		idr(8'h92, 8'h00, {16'h0, m, d, m, d}, 1);
		idr(8'h92, 8'h01, {16'h0, d, m, d, m}, 1);
		idr(8'h94, 8'h01, 48'h0, 0);
		@(posedge sys_clk);
		quad_enable_bit <= 1'b1;
		idr(8'h94, 8'h01, {16'h0, d, m, d, m}, 1);
		idr(8'h94, 8'h00, {16'h0, m, d, m, d}, 1);
		@(posedge sys_clk);
		op_busy <= 1'b1;
		op_kind <= 3'h1;
		idr(8'h9F, 8'h00, 48'h0, 0);
		idr(8'h92, 8'h00, 48'h0, 0);
		acc(8'h06, 0);
		host.frame(8'h75, 48'h0, 0, 1, 0, 1, cap);
		check({44'h0, op_suspend, locked_kind}, 48'h9);
		check({32'h0, status_sus}, 48'h0);
		acc(8'h03, 0);
		acc(8'h05, 1);
		wait_status(16'h0400);
		check(48'(clr_cnt), 48'h1);
		foreach (wr_list[i]) acc(wr_list[i], 1);
		idr(8'h9F, 8'h00, {m, t, c, m, t, c}, 1);
		host.frame(8'h7A, 48'h0, 0, 1, 0, 1, cap);
		check({31'h0, status_sus, op_suspend}, 48'h0);
		@(posedge sys_clk);
		op_kind <= 3'h0;
		host.frame(8'hB0, 48'h0, 0, 1, 0, 1, cap);
		acc(8'h66, 1);
		wait_status(16'h8000);
		check({44'h0, op_suspend, locked_kind}, 48'h8);
		check(48'(clr_cnt), 48'h2);
		foreach (wr_list[i]) acc(wr_list[i], 0);
		foreach (ok_list[i]) acc(ok_list[i], 1);
		idr(8'h92, 8'h01, {16'h0, d, m, d, m}, 1);
		host.frame(8'h30, 48'h0, 0, 1, 0, 1, cap);
		check({31'h0, status_sus, op_suspend}, 48'h0);
		@(posedge sys_clk);
		op_kind <= 3'h5;
		host.frame(8'h75, 48'h0, 0, 1, 0, 1, cap);
		repeat (SUS_CYC + 20) @(posedge sys_clk);
		check({31'h0, status_sus, op_suspend}, 48'h0);
		@(posedge sys_clk);
		op_busy <= 1'b0;
		host.frame(8'hB0, 48'h0, 0, 1, 0, 1, cap);
		repeat (SUS_CYC + 20) @(posedge sys_clk);
		check({31'h0, status_sus, op_suspend}, 48'h0);
		check(48'(clr_cnt), 48'h2);
		complete_run();
	end
endmodule : test_flash_id_read_and_suspend_control
`default_nettype wire
